//--- rtl/cmd_front.sv
// command front end: registers, reset sequencing, block fetch, completion
//
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module cmd_front (
	// clock and reset
	input  wire logic                       clk_sys_in,
	input  wire logic                       srst_in,
	input  wire logic                       channel_reset_line_in,
	// register port
	input  wire logic [2:0]                 addr_in,
	input  wire logic [7:0]                 wdata_in,
	input  wire logic                       wr_in,
	input  wire logic                       rd_in,
	output logic      [7:0]                 rdata_out,
	// diagnostics and execution engine
	input  wire logic [3:0]                 diag_result_in,
	input  wire logic                       done_in,
	input  wire logic [3:0]                 done_dev_in,
	input  wire logic                       done_fail_in,
	// memory read port for block fetch
	output cmd_front_pkg::mem_req_t         mem_req_out,
	input  wire logic                       mem_ack_in,
	input  wire logic [15:0]                mem_data_in,
	// outputs to execution and scsi side
	output logic                            scsi_reset_out,
	output logic                            cache_clear_out,
	output logic                            target_reset_out,
	output logic [3:0]                      target_dev_out,
	output logic                            start_out,
	output logic [3:0]                      start_dev_out,
	output logic                            abort_seq_out,
	output cmd_front_pkg::scb_opts_t        opts_out,
	output logic [31:0]                     chain_addr_out,
	output logic                            irq_out,
	output logic                            dma_en_out
);
	typedef enum logic [2:0] {ST_IDLE, ST_DIAG, ST_DISPATCH, ST_FETCH, ST_START} state_t;
	state_t      state_reg;
	logic [7:0]  cmd_reg [4];
	logic [7:0]  attn_reg;
	logic [7:0]  ctrl_reg;
	logic [7:0]  isr_reg;
	logic        busy_reg;
	logic        full_reg;
	logic        irq_pend_reg;
	logic        failed_reg;
	logic        soft_reg;
	logic [15:0] active_reg;
	logic [7:0]  diag_cnt_reg;
	logic [3:0]  word_reg;
	logic [15:0] scb_reg [cmd_front_pkg::SCB_WORDS];
	logic        post_reg;
	logic [7:0]  post_val_reg;
	logic        hard_rst;
	logic        soft_rst;
	logic        attn_wr;
	logic [3:0]  attn_dev;
	logic [3:0]  attn_req;
	logic [31:0] cmd_word;

	////////////////////////////////////////////////////////////////////////
	// decode helpers
	function automatic logic [31:0] join32(input logic [15:0] lo, input logic [15:0] hi);
		join32 = {hi, lo};
	endfunction : join32

	assign attn_wr  = wr_in && (addr_in == cmd_front_pkg::OFS_ATTN);
	assign attn_dev = wdata_in[3:0];
	assign attn_req = wdata_in[7:4];
	assign cmd_word = {cmd_reg[3], cmd_reg[2], cmd_reg[1], cmd_reg[0]};
	// the hard reset holds for as long as the line or control bit 7 stands
	assign hard_rst = channel_reset_line_in || ctrl_reg[cmd_front_pkg::CTRL_HRST_BIT];
	// immediate reset to the adapter; refused once a reset has failed
	assign soft_rst = (state_reg == ST_DISPATCH) && !failed_reg
		&& (attn_reg[7:4] == cmd_front_pkg::REQ_IMM)
		&& (attn_reg[3:0] == cmd_front_pkg::DEV_ADAPTER)
		&& (cmd_word[5:0] == cmd_front_pkg::OP_RESET);

	////////////////////////////////////////////////////////////////////////
	// command bytes and control register
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			for (int i = 0; i < 4; i++)
				cmd_reg[i] <= 8'h00;
			ctrl_reg <= cmd_front_pkg::CTRL_RESET;
		end
		else if (wr_in)
		begin
			if (addr_in <= cmd_front_pkg::OFS_CMD3)
				cmd_reg[addr_in[1:0]] <= wdata_in;
			else if (addr_in == cmd_front_pkg::OFS_CTRL)
				ctrl_reg <= wdata_in & 8'h83;
		end
	end

	// full flag: set once the last byte is loaded, cleared when consumed
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in || hard_rst)
			full_reg <= 1'b0;
		else if (wr_in && addr_in == cmd_front_pkg::OFS_CMD3)
			full_reg <= 1'b1;
		else if (state_reg == ST_DISPATCH)
			full_reg <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// main sequencer
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			state_reg    <= ST_DIAG;
			busy_reg     <= 1'b1;
			diag_cnt_reg <= 8'h00;
			soft_reg     <= 1'b0;
			failed_reg   <= 1'b0;
			attn_reg     <= 8'h00;
			word_reg     <= 4'h0;
			active_reg   <= 16'h0000;
		end
		else if (hard_rst)
		begin
			state_reg    <= ST_DIAG;
			busy_reg     <= 1'b1;
			diag_cnt_reg <= 8'h00;
			soft_reg     <= 1'b0;
			failed_reg   <= 1'b0;
			active_reg   <= 16'h0000;
		end
		else
		begin
			if (done_in)
				active_reg[done_dev_in] <= 1'b0;
			unique case (state_reg)
				ST_IDLE:
				begin
					if (attn_wr && attn_req != cmd_front_pkg::REQ_EOI)
					begin
						attn_reg  <= wdata_in;
						busy_reg  <= 1'b1;
						state_reg <= ST_DISPATCH;
					end
				end
				ST_DIAG:
				begin
					diag_cnt_reg <= diag_cnt_reg + 8'h01;
					if (diag_cnt_reg == cmd_front_pkg::DIAG_CYCLES)
					begin
						failed_reg <= (diag_result_in != cmd_front_pkg::RST_OK);
						busy_reg   <= 1'b0;
						state_reg  <= ST_IDLE;
					end
				end
				ST_DISPATCH:
				begin
					word_reg <= 4'h0;
					if (soft_rst)
					begin
						// soft reset drops every pending command
						active_reg   <= 16'h0000;
						soft_reg     <= 1'b1;
						diag_cnt_reg <= 8'h00;
						state_reg    <= ST_DIAG;
					end
					else if (failed_reg || active_reg[attn_reg[3:0]])
					begin
						// new command discarded; running one ends with an error
						busy_reg  <= 1'b0;
						state_reg <= ST_IDLE;
					end
					else if (attn_reg[7:4] == cmd_front_pkg::REQ_SCB)
						state_reg <= ST_FETCH;
					else
						state_reg <= ST_START;
				end
				ST_FETCH:
				begin
					// busy drops, though the fetch still takes its pointer from the command bytes
					busy_reg <= 1'b0;
					if (mem_ack_in)
					begin
						word_reg <= word_reg + 4'h1;
						if (word_reg == cmd_front_pkg::SCB_LAST)
							state_reg <= ST_START;
					end
				end
				ST_START:
				begin
					busy_reg                  <= 1'b0;
					active_reg[attn_reg[3:0]] <= 1'b1;
					state_reg                 <= ST_IDLE;
				end
			endcase
		end
	end

	// control block words land in ascending order
	always_ff @(posedge clk_sys_in)
	begin
		if (state_reg == ST_FETCH && mem_ack_in)
			scb_reg[word_reg] <= mem_data_in;
	end

	// fetch address walks up one halfword at a time
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in || hard_rst)
			mem_req_out <= '0;
		else
		begin
			mem_req_out.valid <= (state_reg == ST_FETCH) && !(mem_ack_in
				&& word_reg == cmd_front_pkg::SCB_LAST);
			mem_req_out.addr  <= cmd_word + {27'h0, word_reg + 4'(mem_ack_in), 1'b0};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// option decode and start pulse toward the execution engine
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in || hard_rst)
		begin
			opts_out       <= '0;
			chain_addr_out <= 32'h0;
			start_out      <= 1'b0;
			start_dev_out  <= 4'h0;
		end
		else
		begin
			start_out <= (state_reg == ST_START);
			if (state_reg == ST_START)
			begin
				start_dev_out                  <= attn_reg[3:0];
				opts_out.opcode                <= scb_reg[0][5:0];
				opts_out.cmd_dep               <= scb_reg[0][15:8];
				opts_out.no_disconnect_flag    <= scb_reg[0][cmd_front_pkg::CW_NODISC_BIT];
				opts_out.no_sync_request_flag  <= scb_reg[0][cmd_front_pkg::CW_NOSYNC_BIT];
				opts_out.read_dir              <= scb_reg[1][cmd_front_pkg::OPT_DIR_BIT];
				opts_out.status_on_error_only  <= scb_reg[1][cmd_front_pkg::OPT_ESO_BIT];
				opts_out.retry_enable_flag     <= scb_reg[1][cmd_front_pkg::OPT_RETRY_BIT];
				opts_out.scatter_list_flag     <= scb_reg[1][cmd_front_pkg::OPT_LIST_BIT];
				opts_out.short_ok              <= scb_reg[1][cmd_front_pkg::OPT_SHORT_BIT];
				opts_out.cache_bypass_flag     <= scb_reg[1][cmd_front_pkg::OPT_BYP_BIT];
				opts_out.chain_on_success_flag <= scb_reg[1][cmd_front_pkg::OPT_CHAIN_BIT];
				chain_addr_out                 <= join32(scb_reg[10], scb_reg[11]);
			end
		end
	end

	// reset side effects: scsi bus only on soft reset to the adapter
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			scsi_reset_out   <= 1'b0;
			cache_clear_out  <= 1'b1;
			target_reset_out <= 1'b0;
			target_dev_out   <= 4'h0;
			abort_seq_out    <= 1'b0;
		end
		else
		begin
			scsi_reset_out   <= soft_rst && !hard_rst;
			cache_clear_out  <= hard_rst;
			target_reset_out <= !hard_rst && state_reg == ST_DISPATCH && !failed_reg
				&& attn_reg[7:4] == cmd_front_pkg::REQ_IMM
				&& attn_reg[3:0] != cmd_front_pkg::DEV_ADAPTER
				&& cmd_word[5:0] == cmd_front_pkg::OP_RESET;
			target_dev_out   <= attn_reg[3:0];
			abort_seq_out    <= !hard_rst && state_reg == ST_DISPATCH && !soft_rst
				&& !failed_reg && active_reg[attn_reg[3:0]];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// completion posting: one report outstanding until end of interrupt
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in || hard_rst) // a hard reset drops any stale report
		begin
			post_reg     <= 1'b0;
			post_val_reg <= 8'h00;
		end
		else if (state_reg == ST_DIAG && diag_cnt_reg == cmd_front_pkg::DIAG_CYCLES
			&& !hard_rst)
		begin
			post_reg     <= 1'b1;
			post_val_reg <= soft_reg ? ((diag_result_in == cmd_front_pkg::RST_OK)
				? cmd_front_pkg::SOFT_OK : cmd_front_pkg::SOFT_FAIL)
				: {diag_result_in, cmd_front_pkg::DEV_ADAPTER};
		end
		else if (done_in && !failed_reg)
		begin
			post_reg     <= 1'b1;
			post_val_reg <= {done_fail_in ? cmd_front_pkg::ID_FAIL
				: cmd_front_pkg::ID_SCB_OK, done_dev_in};
		end
		else if (post_reg && !irq_pend_reg)
			post_reg <= 1'b0;
	end

	// status register and interrupt latch
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in || hard_rst) // otherwise an old report hides the reset result
		begin
			isr_reg      <= cmd_front_pkg::ISR_RESET;
			irq_pend_reg <= 1'b0;
		end
		else if (post_reg && !irq_pend_reg)
		begin
			isr_reg      <= post_val_reg;
			irq_pend_reg <= 1'b1;
		end
		else if (attn_wr && attn_req == cmd_front_pkg::REQ_EOI)
		begin
			isr_reg      <= cmd_front_pkg::ISR_RESET;
			irq_pend_reg <= 1'b0;
		end
	end

	// interrupt and dma enables gate the outgoing levels
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			irq_out    <= 1'b0;
			dma_en_out <= 1'b0;
		end
		else
		begin
			irq_out    <= irq_pend_reg && ctrl_reg[cmd_front_pkg::CTRL_IEN_BIT];
			dma_en_out <= ctrl_reg[cmd_front_pkg::CTRL_DMA_BIT] && !hard_rst;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port, data one cycle after the strobe
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
			rdata_out <= 8'h00;
		else if (rd_in)
		begin
			unique case (addr_in)
				cmd_front_pkg::OFS_ATTN:   rdata_out <= attn_reg;
				cmd_front_pkg::OFS_CTRL:   rdata_out <= ctrl_reg;
				cmd_front_pkg::OFS_ISR:    rdata_out <= isr_reg;
				cmd_front_pkg::OFS_STATUS: rdata_out <= {4'h0, full_reg,
					!full_reg, irq_pend_reg, busy_reg};
				default:                   rdata_out <= cmd_reg[addr_in[1:0]];
			endcase
		end
		else
			rdata_out <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	AST_HARD_BUSY: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		hard_rst |=> busy_reg)
		else $error("busy not set by hard reset");
	AST_NO_BUS_RESET_HARD: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		hard_rst |=> !scsi_reset_out)
		else $error("scsi reset during hard reset");
	AST_ISR_HOLD: assert property (@(posedge clk_sys_in) disable iff (srst_in || hard_rst)
		irq_pend_reg && !(attn_wr && attn_req == cmd_front_pkg::REQ_EOI)
		|=> $stable(isr_reg))
		else $error("status changed while interrupt pending");
	AST_EOI_CLEAR: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		irq_pend_reg && attn_wr && attn_req == cmd_front_pkg::REQ_EOI
		|=> !irq_pend_reg && isr_reg == cmd_front_pkg::ISR_RESET)
		else $error("end of interrupt did not clear status");
	AST_ATTN_BUSY: assert property (@(posedge clk_sys_in) disable iff (srst_in || hard_rst)
		state_reg == ST_IDLE && attn_wr && attn_req != cmd_front_pkg::REQ_EOI
		|=> busy_reg)
		else $error("busy not set on attention");
	AST_FAILED_REFUSE: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		failed_reg && state_reg == ST_DISPATCH && !hard_rst
		|=> state_reg == ST_IDLE && !start_out)
		else $error("command accepted after failed reset");
	AST_SEQ_ERR: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		state_reg == ST_DISPATCH && !hard_rst && !soft_rst && !failed_reg
		&& active_reg[attn_reg[3:0]] |=> abort_seq_out ##1 !start_out)
		else $error("busy device command not refused");
	AST_SOFT_SCSI: assert property (@(posedge clk_sys_in) disable iff (srst_in)
		soft_rst && !hard_rst |=> scsi_reset_out && state_reg == ST_DIAG)
		else $error("soft reset did not pulse scsi reset");
	AST_FETCH_ORDER: assert property (@(posedge clk_sys_in) disable iff (srst_in || hard_rst)
		state_reg == ST_FETCH && mem_ack_in && word_reg != cmd_front_pkg::SCB_LAST
		|=> mem_req_out.addr == $past(mem_req_out.addr) + 32'h2)
		else $error("fetch address not ascending");
	COV_SCB: cover property (@(posedge clk_sys_in) state_reg == ST_FETCH ##[1:40] start_out);
	COV_EOI: cover property (@(posedge clk_sys_in) irq_pend_reg ##[1:20] !irq_pend_reg);
	COV_SOFT: cover property (@(posedge clk_sys_in) scsi_reset_out);
	COV_SEQ: cover property (@(posedge clk_sys_in) abort_seq_out);
endmodule : cmd_front
`default_nettype wire

//--- rtl/cmd_front_pkg.sv
// package: constants and carriers for the host adapter command front end
package cmd_front_pkg;
	// register offsets on the plain port
	localparam logic [2:0] OFS_CMD0   = 3'h0;
	localparam logic [2:0] OFS_CMD3   = 3'h3;
	localparam logic [2:0] OFS_ATTN   = 3'h4;
	localparam logic [2:0] OFS_CTRL   = 3'h5;
	localparam logic [2:0] OFS_ISR    = 3'h6;
	localparam logic [2:0] OFS_STATUS = 3'h7;
	// field positions
	localparam int CTRL_HRST_BIT = 7;
	localparam int CTRL_DMA_BIT  = 1;
	localparam int CTRL_IEN_BIT  = 0;
	localparam int CW_NODISC_BIT = 7;
	localparam int CW_NOSYNC_BIT = 6;
	localparam int OPT_DIR_BIT   = 15;
	localparam int OPT_ESO_BIT   = 14;
	localparam int OPT_RETRY_BIT = 13;
	localparam int OPT_LIST_BIT  = 12;
	localparam int OPT_SHORT_BIT = 10;
	localparam int OPT_BYP_BIT   = 9;
	localparam int OPT_CHAIN_BIT = 0;
	// request codes in attention bits 7-4
	localparam logic [3:0] REQ_IMM = 4'h1;
	localparam logic [3:0] REQ_SCB = 4'h3;
	localparam logic [3:0] REQ_EOI = 4'he;
	// device numbers and interrupt ids
	localparam logic [3:0] DEV_ADAPTER = 4'hf;
	localparam logic [3:0] ID_SCB_OK   = 4'h1;
	localparam logic [3:0] ID_HW_FAIL  = 4'h7;
	localparam logic [3:0] ID_IMM_OK   = 4'ha;
	localparam logic [3:0] ID_FAIL     = 4'hc;
	localparam logic [3:0] ID_SEQ_ERR  = 4'hf;
	localparam logic [3:0] RST_OK      = 4'h0;
	localparam logic [7:0] SOFT_OK     = 8'haf;
	localparam logic [7:0] SOFT_FAIL   = 8'h7f;
	localparam logic [5:0] OP_RESET    = 6'h00;
	localparam logic [7:0] ISR_RESET   = 8'h00;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	// number of 16-bit words in a control block
	localparam int          SCB_WORDS  = 14;
	localparam logic [3:0]  SCB_LAST   = 4'(SCB_WORDS - 1);
	// self-test length in cycles
	localparam logic [7:0]  DIAG_CYCLES = 8'h20;
	// fetch request toward system memory
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
	} mem_req_t;
	// decoded options of the active block
	typedef struct packed {
		logic no_disconnect_flag;
		logic no_sync_request_flag;
		logic read_dir;
		logic status_on_error_only;
		logic retry_enable_flag;
		logic scatter_list_flag;
		logic short_ok;
		logic cache_bypass_flag;
		logic chain_on_success_flag;
		logic [5:0] opcode;
		logic [7:0] cmd_dep;
	} scb_opts_t;
endpackage : cmd_front_pkg

//--- testbench/mem_model.sv
// memory partner: answers control block word fetches, prompt or slow
`timescale 1ns/10ps
`default_nettype none
module mem_model (
	// clock and reset
	input  wire logic                    clk_sys_in,
	input  wire logic                    srst_in,
	// fetch port
	input  wire cmd_front_pkg::mem_req_t req_in,
	input  wire logic                    slow_in,
	output logic                         ack_out,
	output logic [15:0]                  data_out
);
	logic [15:0] mem [0:15];
	logic [1:0]  wait_reg;
	////////////////////////////////////////////////////////////////////////
	// one word per ack; idle data toggles so a stale word never passes
	always_ff @(posedge clk_sys_in)
	begin
		if (srst_in)
		begin
			ack_out  <= 1'b0;
			wait_reg <= 2'h0;
			data_out <= 16'h5a5a;
		end
		else if (ack_out)
		begin
			ack_out  <= 1'b0;
			wait_reg <= slow_in ? 2'h3 : 2'h0;
			data_out <= ~data_out;
		end
		else if (req_in.valid && wait_reg == 2'h0)
		begin
			ack_out  <= 1'b1;
			data_out <= mem[req_in.addr[4:1]];
		end
		else
		begin
			wait_reg <= wait_reg - {1'b0, wait_reg != 2'h0};
			data_out <= ~data_out;
		end
	end
endmodule : mem_model
`default_nettype wire

//--- testbench/test_cmd_front.sv
// testbench: register port stimulus, queued expectations, output watch
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module test_cmd_front;
	typedef struct packed {
		logic                     full;
		logic [3:0]               dev;
		cmd_front_pkg::scb_opts_t o;
		logic [31:0]              ch;
	} start_exp_t;
	logic                     clk_sys_in, srst_in, channel_reset_line_in, wr_in, rd_in;
	logic                     done_in, done_fail_in, mem_ack_in, scsi_reset_out;
	logic                     cache_clear_out, target_reset_out, start_out, abort_seq_out;
	logic                     irq_out, dma_en_out, chk, chk_d, slow;
	logic [2:0]               addr_in;
	logic [7:0]               wdata_in, rdata_out, rval, rexp;
	logic [3:0]               diag_result_in, done_dev_in, target_dev_out, start_dev_out;
	logic [3:0]               abort_dev, trst_dev;
	logic [15:0]              mem_data_in, w [0:13];
	logic [31:0]              chain_addr_out, exp_addr;
	cmd_front_pkg::mem_req_t  mem_req_out;
	cmd_front_pkg::scb_opts_t opts_out;
	start_exp_t               se;
	int                       miscompares, n_tests, cycles, n_scsi, n_abort, j, seed;
	logic [7:0]               rd_q [$];
	start_exp_t               st_q [$];
	cmd_front cmd_front_inst (.clk_sys_in, .srst_in, .channel_reset_line_in, .addr_in,
		.wdata_in, .wr_in, .rd_in, .rdata_out, .diag_result_in, .done_in, .done_dev_in,
		.done_fail_in, .mem_req_out, .mem_ack_in, .mem_data_in, .scsi_reset_out,
		.cache_clear_out, .target_reset_out, .target_dev_out, .start_out, .start_dev_out,
		.abort_seq_out, .opts_out, .chain_addr_out, .irq_out, .dma_en_out);
	mem_model mem_model_inst (.clk_sys_in, .srst_in, .req_in(mem_req_out), .slow_in(slow),
		.ack_out(mem_ack_in), .data_out(mem_data_in));
	////////////////////////////////////////////////////////////////////////
	// 40 MHz clock
	initial
	begin
		clk_sys_in = 1'b0;
		forever #12.5 clk_sys_in = ~clk_sys_in;
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : end_sim
	////////////////////////////////////////////////////////////////////////
	// watcher: pops the oldest note whenever a result shows
	always @(posedge clk_sys_in)
	begin
		cycles++;
		chk_d <= chk && rd_in;
		if (chk_d)
		begin
			rexp = rd_q.pop_front();
			`CHK("rdata", rexp, rdata_out)
		end
		if (start_out && st_q.size() == 0)
			`CHK("unexpected start", 1'b0, start_out)
		else if (start_out)
		begin
			se = st_q.pop_front();
			`CHK("start dev", se.dev, start_dev_out)
			if (se.full)
			begin
				`CHK("opts", se.o, opts_out)
				`CHK("chain", se.ch, chain_addr_out)
			end
		end
		if (mem_ack_in)
		begin
			`CHK("fetch addr", exp_addr, mem_req_out.addr)
			exp_addr = exp_addr + 32'h2;
		end
		if (scsi_reset_out)
			n_scsi++;
		if (target_reset_out)
			trst_dev = target_dev_out;
		if (abort_seq_out)
		begin
			n_abort++;
			abort_dev = target_dev_out;
		end
		if (cycles == 20000)
		begin
			miscompares++;
			$display("CHECK FAILED timeout");
			end_sim();
		end
	end
	////////////////////////////////////////////////////////////////////////
	// register port master: strobes one cycle, changed just after an edge
	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [2:0] a, input logic c, input logic [7:0] e);
		if (c)
			rd_q.push_back(e);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in <= 1'b1;
		chk <= c;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		chk <= 1'b0;
		@(negedge clk_sys_in);
		rval = rdata_out;
	endtask : rd_reg
	task automatic isr(input logic [7:0] e);
		rd_reg(cmd_front_pkg::OFS_ISR, 1'b1, e);
	endtask : isr
	// bounded status poll, well inside the host time-out
	task automatic wait_stat(input logic [7:0] m, input logic [7:0] v);
		int k;
		for (k = 0; k < 400; k++)
		begin
			rd_reg(cmd_front_pkg::OFS_STATUS, 1'b0, 8'h00);
			if ((rval & m) === v)
				break;
		end
		`CHK("status wait", v, rval & m)
	endtask : wait_stat
	task automatic cmd(input logic [3:0] dev, input logic [3:0] req, input logic [31:0] c);
		int k;
		wait_stat(8'h01, 8'h00);
		for (k = 0; k < 4; k++)
			wr_reg(cmd_front_pkg::OFS_CMD0 + 3'(k), c[8*k +: 8]);
		wr_reg(cmd_front_pkg::OFS_ATTN, {req, dev});
	endtask : cmd
	task automatic end_of_interrupt_request(input logic [3:0] dev);
		wr_reg(cmd_front_pkg::OFS_ATTN, {cmd_front_pkg::REQ_EOI, dev});
		repeat (12) @(posedge clk_sys_in);
	endtask : end_of_interrupt_request
	task automatic fin(input logic [3:0] dev, input logic f);
		@(posedge clk_sys_in);
		done_in <= 1'b1;
		done_dev_in <= dev;
		done_fail_in <= f;
		@(posedge clk_sys_in);
		done_in <= 1'b0;
	endtask : fin
	task automatic hard_line(input logic [3:0] d);
		@(posedge clk_sys_in);
		diag_result_in <= d;
		channel_reset_line_in <= 1'b1;
		repeat (20) @(posedge clk_sys_in);
		channel_reset_line_in <= 1'b0;
		wait_stat(8'h03, 8'h02);
	endtask : hard_line
	// block at an aligned pointer, random words from the memory side
	task automatic memory_command_block(input logic [3:0] dev, input logic s);
		start_exp_t e;
		int k;
		for (k = 0; k < 14; k++)
		begin
			w[k] = 16'($random(seed));
			mem_model_inst.mem[k] = w[k];
		end
		e.full = 1'b1;
		e.dev = dev;
		e.o = {w[0][7:6], w[1][15:12], w[1][10:9], w[1][0], w[0][5:0], w[0][15:8]};
		e.ch = {w[11], w[10]};
		slow <= s;
		exp_addr = 32'h40;
		st_q.push_back(e);
		cmd(dev, cmd_front_pkg::REQ_SCB, 32'h0000_0040);
		for (k = 0; k < 300 && st_q.size() != 0; k++)
			@(posedge clk_sys_in);
		`CHK("block started", 0, st_q.size())
	endtask : memory_command_block
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		seed = 32'h79c5;
		srst_in = 1'b1;
		{channel_reset_line_in, wr_in, rd_in, done_in, done_fail_in, chk, slow} = '0;
		{chk_d, addr_in, wdata_in, diag_result_in, done_dev_in} = '0;
		repeat (10) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		wait_stat(8'h03, 8'h02);
		isr(8'h0f);
		isr(8'h0f);
		end_of_interrupt_request(4'hf);
		isr(8'h00);
		$display("test power-up done");
		@(posedge clk_sys_in);
		diag_result_in <= 4'h3;
		wr_reg(cmd_front_pkg::OFS_CTRL, 8'h80);
		repeat (2000) @(posedge clk_sys_in);
		`CHK("cache clear", 1'b1, cache_clear_out)
		wr_reg(cmd_front_pkg::OFS_CTRL, cmd_front_pkg::CTRL_RESET);
		wait_stat(8'h03, 8'h02);
		isr(8'h3f);
		hard_line(4'h0);
		isr(8'h0f);
		end_of_interrupt_request(4'hf);
		`CHK("no bus reset", 0, n_scsi)
		$display("test hard reset done");
		for (j = 0; j < 2; j++)
		begin
			diag_result_in <= j ? 4'h5 : 4'h0;
			cmd(cmd_front_pkg::DEV_ADAPTER, cmd_front_pkg::REQ_IMM, 32'h0);
			wait_stat(8'h03, 8'h02);
			isr(j ? cmd_front_pkg::SOFT_FAIL : cmd_front_pkg::SOFT_OK);
			`CHK("bus reset", j + 1, n_scsi)
			if (j == 0)
				end_of_interrupt_request(4'hf);
		end
		cmd(4'h2, cmd_front_pkg::REQ_IMM, 32'h0000_000c);
		cmd(cmd_front_pkg::DEV_ADAPTER, cmd_front_pkg::REQ_IMM, 32'h0);
		repeat (60) @(posedge clk_sys_in);
		isr(cmd_front_pkg::SOFT_FAIL);
		`CHK("refused reset", 2, n_scsi)
		hard_line(4'h0);
		end_of_interrupt_request(4'hf);
		// a target reset is handed to the engine like any immediate command
		st_q.push_back('{1'b0, 4'h3, '0, '0});
		cmd(4'h3, cmd_front_pkg::REQ_IMM, 32'h0);
		repeat (40) @(posedge clk_sys_in);
		`CHK("target reset dev", 4'h3, trst_dev)
		`CHK("target bus reset", 2, n_scsi)
		end_of_interrupt_request(4'h3);
		$display("test soft reset done");
		wr_reg(cmd_front_pkg::OFS_CTRL, 8'h03);
		st_q.push_back('{1'b0, 4'h2, '0, '0});
		cmd(4'h2, cmd_front_pkg::REQ_IMM, 32'h0000_000c);
		st_q.push_back('{1'b0, 4'h5, '0, '0});
		cmd(4'h5, cmd_front_pkg::REQ_IMM, 32'h0000_000c);
		fin(4'h5, 1'b1);
		wait_stat(8'h02, 8'h02);
		`CHK("irq", 1'b1, irq_out)
		`CHK("dma en", 1'b1, dma_en_out)
		isr({cmd_front_pkg::ID_FAIL, 4'h5});
		fin(4'h2, 1'b0);
		repeat (10) @(posedge clk_sys_in);
		isr({cmd_front_pkg::ID_FAIL, 4'h5});
		end_of_interrupt_request(4'h5);
		wait_stat(8'h02, 8'h02);
		isr({cmd_front_pkg::ID_SCB_OK, 4'h2});
		end_of_interrupt_request(4'h2);
		`CHK("irq cleared", 1'b0, irq_out)
		$display("test overlap done");
		for (j = 0; j < 2; j++)
			memory_command_block(j ? 4'h6 : 4'h4, j[0]);
		$display("test block fetch done");
		st_q.push_back('{1'b0, 4'h7, '0, '0});
		cmd(4'h7, cmd_front_pkg::REQ_IMM, 32'h0000_000c);
		cmd(4'h7, cmd_front_pkg::REQ_IMM, 32'h0000_000c);
		repeat (10) @(posedge clk_sys_in);
		`CHK("abort count", 1, n_abort)
		`CHK("abort dev", 4'h7, abort_dev)
		$display("test sequence error done");
		// dma enable must drop while the channel line holds the adapter in reset
		channel_reset_line_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		`CHK("dma in reset", 1'b0, dma_en_out)
		channel_reset_line_in <= 1'b0;
		end_sim();
	end
endmodule : test_cmd_front
`default_nettype wire
